/* pkg/ilec_defs.vh */
`ifndef ILEC_DEFS_VH
`define ILEC_DEFS_VH

// register offsets on the internal register port
`define ILEC_ADDR_W 8
`define ILEC_OFS_LINK_ERR 8'h06
`define ILEC_OFS_PAR_ERR 8'h07
`define ILEC_OFS_FLAGS 8'h08

// reset values and counter limit
`define ILEC_CNT_RST 8'h00
`define ILEC_FLAGS_RST 8'h00
`define ILEC_CNT_MAX 8'hFF

// flag bit positions
`define ILEC_BIT_WATCHDOG 7
`define ILEC_BIT_DRV_FAULT 6
`define ILEC_BIT_OUT_DATA 5
`define ILEC_BIT_EVENT_DONE 4
`define ILEC_BIT_WAKEUP 3
`define ILEC_BIT_MASTER_CMD 2
`define ILEC_BIT_PAGE1 1
`define ILEC_BIT_LINK_MODE 0

// link mode code for idle
`define ILEC_MODE_IDLE 3'h0

// writable page 1 span and master command address
`define ILEC_PAGE1_LO 8'h1A
`define ILEC_PAGE1_HI 8'h29
`define ILEC_PAGE1_MC 8'h00

`endif

/* hdl/ilec_sat_counter.v */
`timescale 1ns/10ps
`include "ilec_defs.vh"

module ilec_sat_counter (
    // clock and reset
    input wire clk_in,
    input wire srst_in,
    // control
    input wire inc_in,
    input wire clr_in,
    // count
    output reg [7:0] count_out
);

    always @(posedge clk_in) begin
        if (srst_in) begin
            count_out <= `ILEC_CNT_RST;
        end else if (clr_in) begin
            count_out <= `ILEC_CNT_RST;
        end else if (inc_in && (count_out != `ILEC_CNT_MAX)) begin
            count_out <= count_out + 8'h01;
        end
    end

endmodule // ilec_sat_counter

/* hdl/ilec_status.v */
// Overview of operation
// - link error count increments per communication error
// - bad check octet or byte count counts
// - each counter holds up to 255 errors
// - any write clears link error count
// - parity error count increments per parity error
// - any write clears parity error count
// - flags reset zero, readable, write-one clears
// - flags stay set until software clears
// - bit 7 set on watchdog expiry
// - bit 6 set on output driver fault
// - bit 5 set on new output data
// - bit 4 set on master status write
// - bit 3 set on wakeup, idle only
// - bit 2 set on command or page1 00h write
// - bit 1 set on page1 1Ah-29h change
`timescale 1ns/10ps
`include "ilec_defs.vh"

module ilec_status (
    // clock and reset
    input wire clk_in,
    input wire srst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    // link error events, one-cycle pulses from link logic
    input wire check_type_octet_err_in,
    input wire byte_count_err_in,
    input wire other_link_err_in,
    input wire parity_err_in,
    // flag sources, one-cycle pulses unless noted
    input wire watchdog_expired_in,
    input wire driver_fault_in,
    input wire output_process_data_rx_in,
    input wire event_status_code_wr_in,
    input wire wakeup_pulse_in,
    input wire master_cmd_in,
    input wire page1_wr_in,
    input wire [7:0] page1_addr_in,
    input wire page1_changed_in,
    input wire [2:0] link_mode_in,
    // outputs
    output reg [7:0] link_interrupt_flags_out,
    output reg event_flag_clear_out,
    output reg [7:0] link_error_count_out,
    output reg [7:0] parity_error_count_out
);

    wire [7:0] link_err_cnt;
    wire [7:0] par_err_cnt;
    wire link_err;
    wire wr_link_err;
    wire wr_par_err;
    wire wr_flags;
    reg [7:0] flags_r;
    reg [7:0] flags_nxt;
    reg [7:0] set_vec;
    reg [7:0] rdata_nxt;
    reg [2:0] mode_prev_r;
    reg fault_meta_r;
    reg fault_sync_r;
    reg fault_prev_r;

    // flag set conditions, one per bit
    wire set_watchdog;
    wire set_drv_fault;
    wire set_out_data;
    wire set_event_done;
    wire set_wakeup;
    wire set_master_cmd;
    wire page1_in_span;
    wire set_page1;
    wire set_link_mode;

    // fault is a level from the analog driver: flag only on its rising edge
    wire fault_rise = fault_sync_r & ~fault_prev_r;

    function addr_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    // several error sources in one cycle count once
    assign link_err = check_type_octet_err_in | byte_count_err_in | other_link_err_in;
    assign wr_link_err = reg_wr_in && addr_hit(reg_addr_in, `ILEC_OFS_LINK_ERR);
    assign wr_par_err = reg_wr_in && addr_hit(reg_addr_in, `ILEC_OFS_PAR_ERR);
    assign wr_flags = reg_wr_in && addr_hit(reg_addr_in, `ILEC_OFS_FLAGS);

    ilec_sat_counter u_link_cnt (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .inc_in(link_err),
        .clr_in(wr_link_err),
        .count_out(link_err_cnt)
    );

    ilec_sat_counter u_par_cnt (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .inc_in(parity_err_in),
        .clr_in(wr_par_err),
        .count_out(par_err_cnt)
    );

    assign set_watchdog = watchdog_expired_in;
    assign set_drv_fault = fault_rise;
    assign set_out_data = output_process_data_rx_in;
    assign set_event_done = event_status_code_wr_in;
    // wake-up pulses outside idle are ignored
    assign set_wakeup = wakeup_pulse_in & (link_mode_in == `ILEC_MODE_IDLE);
    assign set_master_cmd = master_cmd_in |
        (page1_wr_in & (page1_addr_in == `ILEC_PAGE1_MC));
    assign page1_in_span = (page1_addr_in >= `ILEC_PAGE1_LO) &
        (page1_addr_in <= `ILEC_PAGE1_HI);
    assign set_page1 = page1_wr_in & page1_changed_in & page1_in_span;
    assign set_link_mode = (link_mode_in != mode_prev_r);

    always @* begin
        set_vec = 8'h00;
        set_vec[`ILEC_BIT_WATCHDOG] = set_watchdog;
        set_vec[`ILEC_BIT_DRV_FAULT] = set_drv_fault;
        set_vec[`ILEC_BIT_OUT_DATA] = set_out_data;
        set_vec[`ILEC_BIT_EVENT_DONE] = set_event_done;
        set_vec[`ILEC_BIT_WAKEUP] = set_wakeup;
        set_vec[`ILEC_BIT_MASTER_CMD] = set_master_cmd;
        set_vec[`ILEC_BIT_PAGE1] = set_page1;
        set_vec[`ILEC_BIT_LINK_MODE] = set_link_mode;
    end

    always @* begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_nxt & ~reg_wdata_in;
        end
        // set after clear so a same-cycle event is kept
        flags_nxt = flags_nxt | set_vec;
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        rdata_nxt = reg_rdata_out;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `ILEC_OFS_LINK_ERR: begin
                    rdata_nxt = link_err_cnt;
                end
                `ILEC_OFS_PAR_ERR: begin
                    rdata_nxt = par_err_cnt;
                end
                `ILEC_OFS_FLAGS: begin
                    rdata_nxt = flags_r;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // two stages for the fault level; only the second one is read
    always @(posedge clk_in) begin
        if (srst_in) begin
            fault_meta_r <= 1'h0;
            fault_sync_r <= 1'h0;
        end else begin
            fault_meta_r <= driver_fault_in;
            fault_sync_r <= fault_meta_r;
        end
    end

    // history for the edge and change detectors, reset to idle levels
    always @(posedge clk_in) begin
        if (srst_in) begin
            mode_prev_r <= `ILEC_MODE_IDLE;
            fault_prev_r <= 1'h0;
        end else begin
            mode_prev_r <= link_mode_in;
            fault_prev_r <= fault_sync_r;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            flags_r <= `ILEC_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // flag copy equals the flag register at all times
    always @(posedge clk_in) begin
        if (srst_in) begin
            link_interrupt_flags_out <= `ILEC_FLAGS_RST;
            event_flag_clear_out <= 1'h0;
        end else begin
            link_interrupt_flags_out <= flags_nxt;
            event_flag_clear_out <= event_status_code_wr_in;
        end
    end

    // counter copies trail the counters by one cycle
    always @(posedge clk_in) begin
        if (srst_in) begin
            link_error_count_out <= `ILEC_CNT_RST;
            parity_error_count_out <= `ILEC_CNT_RST;
        end else begin
            link_error_count_out <= link_err_cnt;
            parity_error_count_out <= par_err_cnt;
        end
    end

    // read data holds until the next read strobe
    always @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= rdata_nxt;
        end
    end

endmodule // ilec_status

/* tb/ilec_status_props.sv */
`timescale 1ns/10ps
module ilec_status_props (
    // watched ports
    input logic clk_in, srst_in, reg_wr_in, reg_rd_in, parity_err_in,
    input logic watchdog_expired_in, event_status_code_wr_in, event_flag_clear_out,
    input logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
    input logic [7:0] link_interrupt_flags_out, parity_error_count_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence par_clr_s; reg_wr_in && reg_addr_in == 8'h07; endsequence
    sequence rd_s(ofs); reg_rd_in && reg_addr_in == ofs; endsequence
    wd_flag_a: assert property (watchdog_expired_in |-> ##[1:2] link_interrupt_flags_out[7])
        else $error("watchdog flag not set");
    evt_flag_a: assert property (event_status_code_wr_in |-> ##[1:2] link_interrupt_flags_out[4])
        else $error("event flag not set");
    evt_clear_a: assert property (event_status_code_wr_in |=> event_flag_clear_out)
        else $error("event clear pulse missing");
    flag_sticky_a: assert property ($fell(link_interrupt_flags_out[5]) |->
        $past(reg_wr_in) && $past(reg_addr_in) == 8'h08 && $past(reg_wdata_in[5]))
        else $error("flag dropped without a write");
    par_inc_a: assert property (parity_err_in && !reg_wr_in |=> ##1 parity_error_count_out ==
        ($past(parity_error_count_out) == 8'hFF ? 8'hFF : $past(parity_error_count_out) + 8'h01))
        else $error("parity count step wrong");
    par_clr_a: assert property (par_clr_s |=> ##1 parity_error_count_out == 8'h00)
        else $error("parity count not cleared");
    rd_par_a: assert property (rd_s(8'h07) |=> reg_rdata_out == parity_error_count_out)
        else $error("parity count read wrong");
    rd_flags_a: assert property (rd_s(8'h08) |=> reg_rdata_out == $past(link_interrupt_flags_out))
        else $error("flag read wrong");
    rst_zero_a: assert property (disable iff (1'b0) srst_in |=> link_interrupt_flags_out == 8'h00)
        else $error("flags not zero after reset");
endmodule // ilec_status_props
bind ilec_status ilec_status_props ilec_status_props_i (.clk_in, .srst_in, .reg_wr_in, .reg_rd_in,
    .parity_err_in, .watchdog_expired_in, .event_status_code_wr_in, .event_flag_clear_out,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .link_interrupt_flags_out, .parity_error_count_out);

/* tb/ilec_link_model.sv */
`timescale 1ns/10ps
module ilec_link_model (
    // clock
    input wire clk_in,
    // link events toward the device
    output reg [10:0] ev_out = 11'h000,
    output reg [7:0] addr_out = 8'h00,
    output reg chg_out = 1'b0,
    output reg [2:0] mode_out = 3'h0
);
    // one-cycle event; page address goes stale (inverted) once released
    task hit(input [10:0] e, input [7:0] a, input c);
        @(negedge clk_in) {ev_out, addr_out, chg_out} <= {e, a, c};
        @(negedge clk_in) {ev_out, addr_out} <= {11'h000, ~a};
    endtask
endmodule // ilec_link_model

/* tb/ilec_status_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module ilec_status_test;
    reg clk_in = 0, srst_in = 1, wr = 0, rd = 0;
    reg [7:0] a = 0, d = 0;
    wire ch;
    wire [7:0] q, pa, lc;
    wire [10:0] ev;
    wire [2:0] md;
    int mismatches = 0, checks_done = 0;
    initial forever #2 clk_in = ~clk_in;
    ilec_link_model ilec_link_model_i (.clk_in(clk_in), .ev_out(ev), .addr_out(pa), .chg_out(ch),
        .mode_out(md));
    ilec_status ilec_status_i (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(a), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(d), .reg_rdata_out(q), .check_type_octet_err_in(ev[0]),
        .byte_count_err_in(ev[1]), .other_link_err_in(ev[2]), .parity_err_in(ev[3]),
        .watchdog_expired_in(ev[4]), .driver_fault_in(ev[5]), .output_process_data_rx_in(ev[6]),
        .event_status_code_wr_in(ev[7]), .wakeup_pulse_in(ev[8]), .master_cmd_in(ev[9]),
        .page1_wr_in(ev[10]), .page1_addr_in(pa), .page1_changed_in(ch), .link_mode_in(md),
        .link_interrupt_flags_out(), .event_flag_clear_out(), .link_error_count_out(lc),
        .parity_error_count_out());
    task wr_reg(input [7:0] ra, input [7:0] rv);
        @(negedge clk_in) {wr, a, d} <= {1'b1, ra, rv};
        @(negedge clk_in) wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] ra, input [7:0] x);
        @(negedge clk_in) {rd, a} <= {1'b1, ra};
        @(negedge clk_in) rd <= 1'b0;
        `CHK("read", x, q)
    endtask
    // writing ~f first (zero only at the flag bit, ones elsewhere) shows the flag is sticky
    task t_flag(input [10:0] e, input [7:0] p, input c, input [7:0] f);
        ilec_link_model_i.hit(e, p, c);
        wr_reg(8'h08, ~f);
        rd_reg(8'h08, f);
        wr_reg(8'h08, f);
        rd_reg(8'h08, 8'h00);
    endtask
    // mid-run reset; mode back to idle under reset so no mode change follows release
    task t_reset;
        ilec_link_model_i.hit(11'h018, 0, 0);
        @(negedge clk_in) begin
            srst_in <= 1'b1;
            ilec_link_model_i.mode_out <= 3'h0;
        end
        repeat (2) @(negedge clk_in);
        srst_in <= 1'b0;
        rd_reg(8'h08, 8'h00);
        rd_reg(8'h07, 8'h00);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) srst_in <= 1'b0;
        rd_reg(8'h08, 8'h00);
        for (int i = 0; i < 4; i++) ilec_link_model_i.hit(i ? 11'h001 << (i - 1) : 11'h007, 0, 0);
        rd_reg(8'h06, 8'h04);
        `CHK("link count out", 8'h04, lc)
        wr_reg(8'h06, 8'h5A);
        rd_reg(8'h06, 8'h00);
        repeat (256) ilec_link_model_i.hit(11'h008, 0, 0);
        rd_reg(8'h07, 8'hFF);
        wr_reg(8'h07, 8'hA5);
        rd_reg(8'h07, 8'h00);
        t_flag(11'h010, 0, 0, 8'h80);
        t_flag(11'h020, 0, 0, 8'h40);
        t_flag(11'h040, 0, 0, 8'h20);
        t_flag(11'h080, 0, 0, 8'h10);
        t_flag(11'h100, 0, 0, 8'h08);
        t_flag(11'h200, 0, 0, 8'h04);
        t_flag(11'h400, 8'h00, 1, 8'h04);
        t_flag(11'h400, 8'h1A, 1, 8'h02);
        t_flag(11'h400, 8'h29, 1, 8'h02);
        t_flag(11'h400, 8'h2A, 1, 8'h00);
        @(negedge clk_in) ilec_link_model_i.mode_out <= 3'h1;
        t_flag(11'h000, 0, 0, 8'h01);
        t_flag(11'h100, 0, 0, 8'h00);
        wr_reg(8'h09, 8'hFF);
        rd_reg(8'h09, 8'h00);
        t_reset;
        give_verdict;
    end
    initial begin
        #20000;
        mismatches++;
        give_verdict;
    end
endmodule // ilec_status_test
